// >>> design/cmac_top.sv
// Run/stop mode control and password gated host access.
//
// Functional notes
// - Stopped: no execution, accepts download/config.
// - Running: executes program, refuses download/config.
// - Mode indicator always shows run or stop.
// - Switch to stop position stops execution.
// - Switch to run position starts execution.
// - Terminal position keeps mode, allows host.
// - Power-up in stop/terminal enters stopped.
// - Power-up in run position enters running.
// - Host mode changes refused in stop position.
// - Halt instruction moves device to stopped.
// - Three protection levels, default level one.
// - Correct password authorizes every restricted function.
// - Data, start/stop, clock always unrestricted.
// - Level 3 also protects forced-data read, upload.
// - Authorization per host, one host only.
// - Authorization revoked one minute after disconnect.
// - Clearing password overrides delete and clear-all protection.
// - Clear-all stops, restores defaults, keeps node/clock and analog image.
// - Clear-all leaves memory cartridge untouched.
// - Clear: digital outputs off, analog frozen.
// - Level/password change after configuration download.
// - Run-to-stop: outputs safe or hold; analog kept.
//
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "cmac_defs.svh"

module cmac_top #(
    parameter int HOST_ID_W = 4,
    parameter longint HOLD_CYCLES = longint'(`CMAC_HOLD_S) * `CMAC_CLK_HZ
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire cmac_pkg::cmac_ahb_req_type AHB_REQ,
    output cmac_pkg::cmac_ahb_rsp_type AHB_RSP,
    input wire logic [1:0] MODE_SWITCH,
    input wire logic LINK_UP,
    input wire logic [HOST_ID_W-1:0] HOST_ID,
    input wire logic HALT_EXEC,
    output logic RUN_LED,
    output logic PROG_EXEC,
    output logic [7:0] DOUT,
    output logic [15:0] AOUT,
    output logic CART_WRITE
);
    import cmac_pkg::*;

    // Limited counter width keeps the hold timer small; larger holds are refused.
    initial begin
        if (HOST_ID_W < 1 || HOST_ID_W > 16 || HOLD_CYCLES < 1 || HOLD_CYCLES > 64'h0000_00ff_ffff_ffff) begin
            $error("cmac_top: unsupported parameter value");
        end
    end

    logic rst_s1_reg;
    logic rst_s2_reg;
    wire logic rst_n;

    // Reset is released through two flops so all state leaves reset on one edge.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_n = rst_s2_reg;

    logic [1:0] sw_s1_reg;
    logic [1:0] sw_s2_reg;
    logic [1:0] sw_s3_reg;
    logic link_s1_reg;
    logic link_s2_reg;
    logic halt_s1_reg;
    logic halt_s2_reg;
    logic [HOST_ID_W-1:0] id_s1_reg;
    logic [HOST_ID_W-1:0] id_s2_reg;

    // Pin inputs come from outside the clock domain and are double-synchronised.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sw_s1_reg <= 2'h0;
            sw_s2_reg <= 2'h0;
            sw_s3_reg <= 2'h0;
            link_s1_reg <= 1'b0;
            link_s2_reg <= 1'b0;
            halt_s1_reg <= 1'b0;
            halt_s2_reg <= 1'b0;
            id_s1_reg <= '0;
            id_s2_reg <= '0;
        end else begin
            sw_s1_reg <= MODE_SWITCH;
            sw_s2_reg <= sw_s1_reg;
            sw_s3_reg <= sw_s2_reg;
            link_s1_reg <= LINK_UP;
            link_s2_reg <= link_s1_reg;
            halt_s1_reg <= HALT_EXEC;
            halt_s2_reg <= halt_s1_reg;
            id_s1_reg <= HOST_ID;
            id_s2_reg <= id_s1_reg;
        end
    end

    cmac_switch_type sw;
    logic [1:0] sw_prev_reg;
    logic [`CMAC_SW_SETTLE-1:0] sw_arm_reg;
    logic sw_valid_reg;
    logic link_prev_reg;
    wire logic sw_steady;
    assign sw = cmac_switch_type'(sw_s3_reg);
    // Both switch bits move on a terminal/run change, so a skewed one-cycle sample is never a position.
    assign sw_steady = (sw_s3_reg == sw_s2_reg);

    // Last steady switch position and link sample; power-up waits until the filter holds the pin.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sw_prev_reg <= 2'h0;
            sw_arm_reg <= '0;
            sw_valid_reg <= 1'b0;
            link_prev_reg <= 1'b0;
        end else begin
            if (sw_steady) begin
                sw_prev_reg <= sw_s3_reg;
            end
            sw_arm_reg <= {sw_arm_reg[`CMAC_SW_SETTLE-2:0], 1'b1};
            sw_valid_reg <= sw_arm_reg[`CMAC_SW_SETTLE-1];
            link_prev_reg <= link_s2_reg;
        end
    end

    // Bus address phase capture.
    logic [7:0] addr_reg;
    logic wr_reg;
    wire logic ap_valid;
    assign ap_valid = AHB_REQ.hsel && AHB_REQ.hready && AHB_REQ.htrans[1];
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg <= 8'h00;
            wr_reg <= 1'b0;
        end else begin
            addr_reg <= AHB_REQ.haddr;
            wr_reg <= ap_valid && AHB_REQ.hwrite;
        end
    end

    wire logic wr_req;
    wire logic [3:0] req_code;
    assign wr_req = wr_reg && (addr_reg == `CMAC_OFS_REQ);
    assign req_code = AHB_REQ.hwdata[3:0];

    // Staged configuration, loaded into the active set by a configuration download.
    logic [1:0] lvl_reg;
    logic [31:0] pwd_reg;
    logic [1:0] lvl_stage_reg;
    logic [31:0] pwd_stage_reg;
    logic [31:0] cand_reg;
    logic [7:0] safe_reg;
    logic hold_dout_reg;
    logic [7:0] node_reg;
    logic [7:0] dimg_reg;
    logic [15:0] aimg_reg;
    cmac_mode_type mode_reg;
    cmac_mode_type mode_next;
    logic [1:0] resp_reg;
    logic auth_reg;
    logic [HOST_ID_W-1:0] auth_id_reg;
    logic [39:0] hold_cnt_reg;
    logic holding_reg;
    logic cleared_reg;

    // Authorization decision for the current request.
    logic restricted;
    logic host_auth;
    logic accept;
    always_comb begin
        host_auth = auth_reg && (auth_id_reg == id_s2_reg);
        restricted = 1'b0;
        case (req_code)
            `CMAC_REQ_DOWNLOAD, `CMAC_REQ_CONFIG, `CMAC_REQ_DELETE, `CMAC_REQ_FORCE,
            `CMAC_REQ_SCAN, `CMAC_REQ_CARTCOPY: restricted = (lvl_reg != `CMAC_LVL_1);
            `CMAC_REQ_RDFORCE, `CMAC_REQ_UPLOAD: restricted = (lvl_reg == `CMAC_LVL_3);
            default: restricted = 1'b0;
        endcase
        accept = !restricted || host_auth;
        case (req_code)
            `CMAC_REQ_DOWNLOAD, `CMAC_REQ_CONFIG: accept = accept && (mode_reg == CMAC_STOPPED);
            `CMAC_REQ_RUN, `CMAC_REQ_STOP: accept = (sw != CMAC_SW_STOP);
            `CMAC_REQ_LOGIN: accept = (cand_reg == pwd_reg) && (!auth_reg || host_auth);
            `CMAC_REQ_CLEARALL: accept = host_auth || lvl_reg == `CMAC_LVL_1 || cand_reg == `CMAC_CLEAR_PWD;
            `CMAC_REQ_DELETE: accept = accept || cand_reg == `CMAC_CLEAR_PWD;
            default: accept = accept;
        endcase
    end

    wire logic do_clear;
    wire logic do_cfg;
    assign do_clear = wr_req && accept && (req_code == `CMAC_REQ_CLEARALL || req_code == `CMAC_REQ_DELETE);
    assign do_cfg = wr_req && accept && (req_code == `CMAC_REQ_CONFIG || req_code == `CMAC_REQ_DOWNLOAD);

    // Operating mode: switch edges, power-up, host, halt and clear.
    always_comb begin
        mode_next = mode_reg;
        if (!sw_valid_reg) begin
            mode_next = (sw == CMAC_SW_RUN) ? CMAC_RUNNING : CMAC_STOPPED;
        end else if (sw_steady && sw_s3_reg != sw_prev_reg && sw == CMAC_SW_STOP) begin
            mode_next = CMAC_STOPPED;
        end else if (sw_steady && sw_s3_reg != sw_prev_reg && sw == CMAC_SW_RUN) begin
            mode_next = CMAC_RUNNING;
        end else if (do_clear && req_code == `CMAC_REQ_CLEARALL) begin
            mode_next = CMAC_STOPPED;
        end else if (halt_s2_reg && mode_reg == CMAC_RUNNING) begin
            mode_next = CMAC_STOPPED;
        end else if (wr_req && accept && req_code == `CMAC_REQ_RUN) begin
            mode_next = CMAC_RUNNING;
        end else if (wr_req && accept && req_code == `CMAC_REQ_STOP) begin
            mode_next = CMAC_STOPPED;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= CMAC_STOPPED;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Response register; a refused request changes nothing else.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            resp_reg <= `CMAC_RSP_NONE;
        end else if (wr_req) begin
            resp_reg <= accept ? `CMAC_RSP_OK : `CMAC_RSP_REJECT;
        end
    end

    // Software registers; clear-all restores defaults except node address and analog image.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            lvl_reg <= `CMAC_LVL_1;
            pwd_reg <= `CMAC_DFLT_PWD;
            lvl_stage_reg <= `CMAC_LVL_1;
            pwd_stage_reg <= `CMAC_DFLT_PWD;
            cand_reg <= 32'h0000_0000;
            safe_reg <= `CMAC_DFLT_SAFE;
            hold_dout_reg <= 1'b0;
            node_reg <= 8'h00;
            dimg_reg <= 8'h00;
            aimg_reg <= 16'h0000;
        end else if (do_clear && req_code == `CMAC_REQ_CLEARALL) begin
            lvl_reg <= `CMAC_LVL_1;
            pwd_reg <= `CMAC_DFLT_PWD;
            lvl_stage_reg <= `CMAC_LVL_1;
            pwd_stage_reg <= `CMAC_DFLT_PWD;
            cand_reg <= 32'h0000_0000;
            safe_reg <= `CMAC_DFLT_SAFE;
            hold_dout_reg <= 1'b0;
            dimg_reg <= 8'h00;
        end else begin
            if (do_cfg) begin
                lvl_reg <= (lvl_stage_reg == 2'h0) ? `CMAC_LVL_1 : lvl_stage_reg;
                pwd_reg <= pwd_stage_reg;
            end
            if (wr_reg) begin
                case (addr_reg)
                    `CMAC_OFS_CFG: begin
                        lvl_stage_reg <= AHB_REQ.hwdata[1:0];
                        hold_dout_reg <= AHB_REQ.hwdata[8];
                    end
                    `CMAC_OFS_PWD: begin
                        pwd_stage_reg <= AHB_REQ.hwdata;
                        cand_reg <= AHB_REQ.hwdata;
                    end
                    `CMAC_OFS_DOUT: dimg_reg <= AHB_REQ.hwdata[7:0];
                    `CMAC_OFS_SAFE: safe_reg <= AHB_REQ.hwdata[7:0];
                    `CMAC_OFS_AOUT: aimg_reg <= AHB_REQ.hwdata[15:0];
                    `CMAC_OFS_NODE: node_reg <= AHB_REQ.hwdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // Authorization holder and one-minute hold after link loss.
    wire logic hold_done;
    assign hold_done = holding_reg && (hold_cnt_reg >= 40'(HOLD_CYCLES - 1));
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            auth_reg <= 1'b0;
            auth_id_reg <= '0;
            holding_reg <= 1'b0;
            hold_cnt_reg <= 40'h00_0000_0000;
        end else if (hold_done || (do_clear && req_code == `CMAC_REQ_CLEARALL)) begin
            auth_reg <= 1'b0;
            holding_reg <= 1'b0;
            hold_cnt_reg <= 40'h00_0000_0000;
        end else if (wr_req && req_code == `CMAC_REQ_LOGIN && accept) begin
            auth_reg <= 1'b1;
            auth_id_reg <= id_s2_reg;
        end else if (link_prev_reg && !link_s2_reg && auth_reg) begin
            holding_reg <= 1'b1;
            hold_cnt_reg <= 40'h00_0000_0000;
        end else if (link_s2_reg && holding_reg && id_s2_reg == auth_id_reg) begin
            holding_reg <= 1'b0;
            hold_cnt_reg <= 40'h00_0000_0000;
        end else if (holding_reg) begin
            hold_cnt_reg <= hold_cnt_reg + 40'h00_0000_0001;
        end
    end

    // Clear marks outputs off until the next run.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cleared_reg <= 1'b0;
        end else if (do_clear && req_code == `CMAC_REQ_CLEARALL) begin
            cleared_reg <= 1'b1;
        end else if (mode_reg == CMAC_RUNNING) begin
            cleared_reg <= 1'b0;
        end
    end

    // Outputs come from flops; stop uses safe values or holds.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RUN_LED <= 1'b0;
            PROG_EXEC <= 1'b0;
            DOUT <= 8'h00;
            AOUT <= `CMAC_AOUT_FROZEN;
            CART_WRITE <= 1'b0;
        end else begin
            RUN_LED <= (mode_next == CMAC_RUNNING);
            PROG_EXEC <= (mode_next == CMAC_RUNNING);
            CART_WRITE <= wr_req && accept && req_code == `CMAC_REQ_CARTCOPY;
            if (cleared_reg || (do_clear && req_code == `CMAC_REQ_CLEARALL)) begin
                DOUT <= 8'h00;
                AOUT <= `CMAC_AOUT_FROZEN;
            end else if (mode_reg == CMAC_RUNNING) begin
                DOUT <= dimg_reg;
                AOUT <= aimg_reg;
            end else if (!hold_dout_reg) begin
                DOUT <= safe_reg;
            end
        end
    end

    // Read data; the slave always answers OKAY with no wait state.
    logic [31:0] rdata;
    logic [31:0] rdata_reg;
    always_comb begin
        rdata = 32'h0000_0000;
        case (AHB_REQ.haddr)
            `CMAC_OFS_STAT: rdata = {24'h00_0000, 3'h0, holding_reg, auth_reg, cleared_reg, 1'b0,
                                     (mode_reg == CMAC_RUNNING)};
            `CMAC_OFS_CFG: rdata = {23'h00_0000, hold_dout_reg, 4'h0, lvl_reg, lvl_stage_reg};
            `CMAC_OFS_RESP: rdata = {30'h0000_0000, resp_reg};
            `CMAC_OFS_DOUT: rdata = {24'h00_0000, dimg_reg};
            `CMAC_OFS_SAFE: rdata = {24'h00_0000, safe_reg};
            `CMAC_OFS_AOUT: rdata = {16'h0000, aimg_reg};
            `CMAC_OFS_NODE: rdata = {24'h00_0000, node_reg};
            `CMAC_OFS_CTRL: rdata = {30'h0000_0000, sw_s2_reg};
            default: rdata = 32'h0000_0000;
        endcase
    end

    // Read data is latched at the address phase so that hrdata comes from a flop.
    // Limitation: a read overlapping the data phase of a write sees the value before that write.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= (ap_valid && !AHB_REQ.hwrite) ? rdata : 32'h0000_0000;
        end
    end
    assign AHB_RSP.hrdata = rdata_reg;
    assign AHB_RSP.hreadyout = 1'b1;
    assign AHB_RSP.hresp = 1'b0;
endmodule
`default_nettype wire

// >>> design/cmac_defs.svh
// Constant definitions for the controller mode and access control block.
`ifndef CMAC_DEFS_SVH
`define CMAC_DEFS_SVH

// Register byte offsets.
`define CMAC_OFS_CTRL 8'h00
`define CMAC_OFS_STAT 8'h04
`define CMAC_OFS_CFG 8'h08
`define CMAC_OFS_PWD 8'h0c
`define CMAC_OFS_REQ 8'h10
`define CMAC_OFS_RESP 8'h14
`define CMAC_OFS_DOUT 8'h18
`define CMAC_OFS_SAFE 8'h1c
`define CMAC_OFS_AOUT 8'h20
`define CMAC_OFS_NODE 8'h24

// Request codes written to the request register.
`define CMAC_REQ_RWDATA 4'h0
`define CMAC_REQ_RUN 4'h1
`define CMAC_REQ_STOP 4'h2
`define CMAC_REQ_CLOCK 4'h3
`define CMAC_REQ_RDFORCE 4'h4
`define CMAC_REQ_UPLOAD 4'h5
`define CMAC_REQ_DOWNLOAD 4'h6
`define CMAC_REQ_DELETE 4'h7
`define CMAC_REQ_FORCE 4'h8
`define CMAC_REQ_SCAN 4'h9
`define CMAC_REQ_CARTCOPY 4'ha
`define CMAC_REQ_LOGIN 4'hb
`define CMAC_REQ_CLEARALL 4'hc
`define CMAC_REQ_CONFIG 4'hd

// Response codes.
`define CMAC_RSP_NONE 2'h0
`define CMAC_RSP_OK 2'h1
`define CMAC_RSP_REJECT 2'h2

// Protection levels.
`define CMAC_LVL_1 2'h1
`define CMAC_LVL_2 2'h2
`define CMAC_LVL_3 2'h3

// Factory values.
`define CMAC_DFLT_PWD 32'h0000_0000
`define CMAC_CLEAR_PWD 32'h636c_7263
`define CMAC_DFLT_SAFE 8'h00
`define CMAC_AOUT_FROZEN 16'h0000

// Authorization hold after link loss.
`define CMAC_HOLD_S 60
`define CMAC_CLK_HZ 250000000

// Switch filter fill time before the power-up position is sampled.
`define CMAC_SW_SETTLE 3

`endif

// >>> design/cmac_pkg.sv
// Types for the controller mode and access control block.
package cmac_pkg;
    typedef enum logic [1:0] {CMAC_SW_STOP, CMAC_SW_TERM, CMAC_SW_RUN} cmac_switch_type;
    typedef enum {CMAC_STOPPED, CMAC_RUNNING} cmac_mode_type;
    typedef struct packed {
        logic [1:0] htrans;
        logic [7:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hsel;
        logic hready;
    } cmac_ahb_req_type;
    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } cmac_ahb_rsp_type;
endpackage

// >>> verification/cmac_asserts.sv
// Port-level checker for the mode control and access gating block.
`timescale 1ns/100ps
`default_nettype none
`include "cmac_defs.svh"
module cmac_asserts (
    input wire logic CLK,
    input wire logic RST_B,
    input wire cmac_pkg::cmac_ahb_req_type AHB_REQ,
    input wire cmac_pkg::cmac_ahb_rsp_type AHB_RSP,
    input wire logic [1:0] MODE_SWITCH,
    input wire logic HALT_EXEC,
    input wire logic RUN_LED,
    input wire logic PROG_EXEC,
    input wire logic CART_WRITE
);
    import cmac_pkg::*;
    logic req_wr_reg;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // Marks a write address phase aimed at the request register.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            req_wr_reg <= 1'b0;
        end else begin
            req_wr_reg <= AHB_REQ.hsel && AHB_REQ.hready && AHB_REQ.htrans[1] && AHB_REQ.hwrite
                && AHB_REQ.haddr == `CMAC_OFS_REQ;
        end
    end
    // Switch held at run with no halt, long enough to pass the synchronizers.
    sequence s_run_held;
        (MODE_SWITCH == 2'h2 && !HALT_EXEC) [*7];
    endsequence
    sequence s_power_run;
        $rose(RST_B) && MODE_SWITCH == 2'h2;
    endsequence
    a_led_tracks_exec: assert property (RUN_LED == PROG_EXEC)
        else $error("Mode indicator differs from execution state.");
    a_stop_switch_halts: assert property ((MODE_SWITCH == 2'h0) [*7] |-> !RUN_LED)
        else $error("Running while switch held at stop.");
    a_run_switch_starts: assert property ((MODE_SWITCH != 2'h2) ##1 s_run_held |-> RUN_LED)
        else $error("Switch moved to run but not running.");
    a_halt_stops: assert property ((HALT_EXEC && $stable(MODE_SWITCH)) [*8] |-> !PROG_EXEC)
        else $error("Program still executing under halt.");
    a_power_run: assert property (s_power_run ##1 s_run_held |-> ##1 RUN_LED)
        else $error("Power-up at run position did not run.");
    a_power_stop: assert property ($rose(RST_B) && MODE_SWITCH != 2'h2 |-> !RUN_LED [*5])
        else $error("Power-up away from run position did not stop.");
    a_cart_from_req: assert property (CART_WRITE |-> $past(req_wr_reg) && $past(AHB_REQ.hwdata[3:0]) == 4'ha)
        else $error("Cartridge written without a copy request.");
    a_bus_okay: assert property (AHB_RSP.hreadyout && !AHB_RSP.hresp)
        else $error("Bus answer not ready or not okay.");
endmodule
bind cmac_top cmac_asserts cmac_asserts_i (.CLK(CLK), .RST_B(RST_B), .AHB_REQ(AHB_REQ), .AHB_RSP(AHB_RSP),
    .MODE_SWITCH(MODE_SWITCH), .HALT_EXEC(HALT_EXEC), .RUN_LED(RUN_LED), .PROG_EXEC(PROG_EXEC),
    .CART_WRITE(CART_WRITE));
`default_nettype wire

// >>> verification/cmac_host_model.sv
// Host programming station model: bus master and link presence.
`timescale 1ns/100ps
`default_nettype none
`include "cmac_defs.svh"
module cmac_host_model (
    input wire logic clk,
    input wire cmac_pkg::cmac_ahb_rsp_type rsp,
    output cmac_pkg::cmac_ahb_req_type req,
    output logic link_up,
    output logic [3:0] host_id
);
    import cmac_pkg::*;
    logic [1:0] trans;
    logic [7:0] addr;
    logic write;
    logic [31:0] wdata;
    // The single slave's ready is looped back as the bus ready.
    assign req = '{htrans: trans, haddr: addr, hwrite: write, hsize: 3'h2, hwdata: wdata, hsel: 1'b1,
        hready: rsp.hreadyout};
    // Idle bus and a connected host at time zero.
    initial begin
        trans = 2'h0;
        addr = 8'h0;
        write = 1'b0;
        wdata = 32'h0;
        link_up = 1'b1;
        host_id = 4'h1;
    end
    // One single word transfer; waits on ready rather than assuming a latency.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        trans <= 2'h2;
        addr <= a;
        write <= wr;
        @(posedge clk);
        while (!rsp.hreadyout) @(posedge clk);
        trans <= 2'h0;
        wdata <= d;
        @(posedge clk);
        while (!rsp.hreadyout) @(posedge clk);
        q = rsp.hrdata;
        wdata <= ~d;
    endtask
    task automatic connect(input logic [3:0] id);
        link_up <= 1'b1;
        host_id <= id;
    endtask
    // A dropped link leaves no stale identity on the wires.
    task automatic drop();
        link_up <= 1'b0;
        host_id <= ~host_id;
    endtask
    // Clear-all is only continued once the clearing password is presented.
    task automatic clear_all(output logic [31:0] r);
        logic [31:0] t;
        xfer(1'b1, `CMAC_OFS_PWD, `CMAC_CLEAR_PWD, t);
        xfer(1'b1, `CMAC_OFS_REQ, {28'h0, `CMAC_REQ_CLEARALL}, t);
        xfer(1'b0, `CMAC_OFS_RESP, 32'h0, r);
    endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the mode control and access gating block.
`timescale 1ns/100ps
`default_nettype none
`include "cmac_defs.svh"
module testbench;
    import cmac_pkg::*;
    localparam int HOLD = 20;
    localparam logic [31:0] PW = 32'h1357_9bdf;
    logic clk, rst_b, halt, run_led, prog_exec, cart_write, link_up;
    logic [1:0] mode_sw;
    logic [3:0] host_id;
    logic [7:0] dout;
    logic [15:0] aout;
    logic [31:0] q;
    cmac_ahb_req_type ahb_req;
    cmac_ahb_rsp_type ahb_rsp;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    int n_cart = 0;
    cmac_top #(.HOST_ID_W(4), .HOLD_CYCLES(HOLD)) cmac_top_i (.CLK(clk), .RST_B(rst_b), .AHB_REQ(ahb_req),
        .AHB_RSP(ahb_rsp), .MODE_SWITCH(mode_sw), .LINK_UP(link_up), .HOST_ID(host_id), .HALT_EXEC(halt),
        .RUN_LED(run_led), .PROG_EXEC(prog_exec), .DOUT(dout), .AOUT(aout), .CART_WRITE(cart_write));
    cmac_host_model cmac_host_model_i (.clk(clk), .rsp(ahb_rsp), .req(ahb_req), .link_up(link_up),
        .host_id(host_id));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // A hang is cut short well beyond the few hundred cycles the run needs.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    // Counts cartridge write pulses; each accepted copy gives exactly one.
    always @(posedge clk) begin
        if (cart_write) begin
            n_cart <= n_cart + 1;
        end
    end
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        cmac_host_model_i.xfer(1'b1, a, d, t);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        cmac_host_model_i.xfer(1'b0, a, 32'h0, d);
    endtask
    task automatic req(input logic [3:0] c, output logic [31:0] r);
        wr(`CMAC_OFS_REQ, {28'h0, c});
        rd(`CMAC_OFS_RESP, r);
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic reset_with(input logic [1:0] sw);
        rst_b <= 1'b0;
        mode_sw <= sw;
        wait_clk(16);
        rst_b <= 1'b1;
        wait_clk(12);
    endtask
    // Data, clock and gated codes up to cartridge copy, delete skipped with rights; without rights the codes from forced-data read upward are refused.
    task automatic run_table(input logic auth);
        logic [35:0] codes = 36'h03456789a;
        logic [3:0] c;
        logic [31:0] r;
        for (int i = 0; i < 9; i++) begin
            c = codes[35 - 4 * i -: 4];
            if (!(auth && c == `CMAC_REQ_DELETE)) begin
                req(c, r);
                chk("resp", r, (c >= 4'h4 && !auth) ? 32'h2 : 32'h1);
            end
        end
    endtask
    task automatic test_power();
        reset_with(2'h2);
        chk("run_led", {31'h0, run_led}, 32'h1);
        reset_with(2'h1);
        chk("run_led", {31'h0, run_led}, 32'h0);
        rd(`CMAC_OFS_CFG, q);
        chk("level", q & 32'hc, 32'h4);
    endtask
    task automatic test_modes();
        req(`CMAC_REQ_CONFIG, q);
        chk("resp", q, 32'h1);
        req(`CMAC_REQ_RUN, q);
        chk("run_led", {31'h0, run_led}, 32'h1);
        req(`CMAC_REQ_CONFIG, q);
        chk("resp", q, 32'h2);
        req(`CMAC_REQ_STOP, q);
        chk("run_led", {31'h0, run_led}, 32'h0);
        mode_sw <= 2'h0;
        wait_clk(10);
        req(`CMAC_REQ_RUN, q);
        chk("resp", q, 32'h2);
        chk("run_led", {31'h0, run_led}, 32'h0);
        mode_sw <= 2'h2;
        wait_clk(10);
        chk("run_led", {31'h0, run_led}, 32'h1);
        mode_sw <= 2'h0;
        wait_clk(10);
        chk("run_led", {31'h0, run_led}, 32'h0);
        mode_sw <= 2'h2;
        wait_clk(10);
        mode_sw <= 2'h1;
        wait_clk(10);
        chk("run_led", {31'h0, run_led}, 32'h1);
        halt <= 1'b1;
        wait_clk(12);
        chk("prog_exec", {31'h0, prog_exec}, 32'h0);
        halt <= 1'b0;
    endtask
    // Stop values go out on a run to stop change; the analog output keeps its value.
    task automatic test_outputs();
        wr(`CMAC_OFS_SAFE, 32'ha5);
        wr(`CMAC_OFS_CFG, 32'h1);
        run_table(1'b1);
        req(`CMAC_REQ_RUN, q);
        wr(`CMAC_OFS_DOUT, 32'h3c);
        wr(`CMAC_OFS_AOUT, 32'h1234);
        req(`CMAC_REQ_STOP, q);
        chk("dout", {24'h0, dout}, 32'ha5);
        chk("aout", {16'h0, aout}, 32'h1234);
    endtask
    task automatic test_access();
        wr(`CMAC_OFS_NODE, 32'h7);
        wr(`CMAC_OFS_PWD, PW);
        wr(`CMAC_OFS_CFG, 32'h3);
        rd(`CMAC_OFS_CFG, q);
        chk("level", q & 32'hc, 32'h4);
        req(`CMAC_REQ_CONFIG, q);
        rd(`CMAC_OFS_CFG, q);
        chk("level", q & 32'hc, 32'hc);
        wr(`CMAC_OFS_PWD, 32'h1);
        run_table(1'b0);
        wr(`CMAC_OFS_PWD, PW);
        req(`CMAC_REQ_LOGIN, q);
        chk("resp", q, 32'h1);
        run_table(1'b1);
        cmac_host_model_i.drop();
        wait_clk(5);
        cmac_host_model_i.connect(4'h1);
        wait_clk(2 * HOLD);
        rd(`CMAC_OFS_STAT, q);
        chk("auth", q & 32'h8, 32'h8);
        cmac_host_model_i.drop();
        wait_clk(2);
        cmac_host_model_i.connect(4'h2);
        req(`CMAC_REQ_LOGIN, q);
        chk("resp", q, 32'h2);
        wait_clk(2 * HOLD);
        rd(`CMAC_OFS_STAT, q);
        chk("auth", q & 32'h18, 32'h0);
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40, q);
        chk("unmapped", q, 32'h0);
    endtask
    task automatic test_clear();
        wr(`CMAC_OFS_PWD, `CMAC_CLEAR_PWD);
        req(`CMAC_REQ_DELETE, q);
        chk("resp", q, 32'h1);
        req(`CMAC_REQ_RUN, q);
        wr(`CMAC_OFS_DOUT, 32'h5a);
        cmac_host_model_i.clear_all(q);
        chk("resp", q, 32'h1);
        chk("run_led", {31'h0, run_led}, 32'h0);
        chk("dout", {24'h0, dout}, 32'h0);
        chk("aout", {16'h0, aout}, {16'h0, `CMAC_AOUT_FROZEN});
        rd(`CMAC_OFS_NODE, q);
        chk("node", q, 32'h7);
        rd(`CMAC_OFS_CFG, q);
        chk("level", q & 32'hc, 32'h4);
        rd(`CMAC_OFS_STAT, q);
        chk("stat", q & 32'h5, 32'h4);
        chk("cart", n_cart, 32'h2);
    endtask
    // Main sequence; the block starts in the terminal position.
    initial begin
        rst_b = 1'b0;
        mode_sw = 2'h1;
        halt = 1'b0;
        @(posedge clk);
        test_power();
        test_modes();
        test_outputs();
        test_access();
        test_clear();
        close_out();
    end
endmodule
`default_nettype wire
